// ==== logic/cca_pkg.sv ====
// constants for the clear channel assessment unit
// assumes a single 100 MHz clock and an 8-bit register port
`default_nettype none
package cca_pkg;
  // register offsets
  localparam logic [7:0] STATUS_ADDR = 8'h01;
  localparam logic [7:0] CTRL_ADDR   = 8'h08;
  localparam logic [7:0] THRES_ADDR  = 8'h09;
  localparam logic [7:0] SYNC_ADDR   = 8'h15;
  // field positions
  localparam int DONE_BIT = 7;
  localparam int IDLE_BIT = 6;
  localparam int REQ_BIT  = 7;
  localparam int MODE_LO  = 5;
  localparam int THR_LO   = 0;
  localparam int PDT_BIT  = 7;
  // reset values
  localparam logic [1:0] MODE_RESET    = 2'h1;
  localparam logic [4:0] CHANNEL_RESET = 5'h00;
  localparam logic [3:0] THR_RESET     = 4'h7;
  localparam logic [3:0] RSVD_RESET    = 4'h7;
  // assessment modes
  localparam logic [1:0] MODE_OR      = 2'h0;
  localparam logic [1:0] MODE_ENERGY  = 2'h1;
  localparam logic [1:0] MODE_CARRIER = 2'h2;
  localparam logic [1:0] MODE_AND     = 2'h3;
  // phy mode codes
  localparam logic [2:0] PHY_BPSK_300  = 3'h0;
  localparam logic [2:0] PHY_BPSK_600  = 3'h1;
  localparam logic [2:0] PHY_OQPSK_400 = 3'h2;
  localparam logic [2:0] PHY_OQPSK_SIN = 3'h3;
  localparam logic [2:0] PHY_OQPSK_RC  = 3'h4;
  // power floors in hundredths of a dBm
  localparam logic signed [17:0] FLOOR_BPSK_CDBM  = -18'sd10000;
  localparam logic signed [17:0] FLOOR_OQPSK_CDBM = -18'sd9800;
  localparam logic signed [17:0] FLOOR_RC_CDBM    = -18'sd9700;
  localparam logic [17:0]        THR_STEP_CDBM    = 18'd207;
  // timing
  localparam logic [3:0] LISTEN_SYMBOLS    = 4'h8;
  localparam logic [3:0] HIGH_RATE_SYMBOLS = 4'h2;
  localparam int CLK_MHZ       = 100;
  localparam int PROC_DELAY_US = 12;
  localparam logic [10:0] PROC_CYCLES = 11'(PROC_DELAY_US * CLK_MHZ);
endpackage
`default_nettype wire

// ==== logic/clear_channel_assessment.sv ====
// clear channel assessment unit: register port, manual and automatic energy
// windows, carrier/energy combination and completion status
// assumes all inputs come from logic on clk; receiver state comes from outside
`default_nettype none
module clear_channel_assessment (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // register port
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  // transceiver state
  input  wire logic [4:0]  trx_state_code,
  input  wire logic        basic_mode,
  input  wire logic        rx_listen,
  input  wire logic        rx_busy,
  input  wire logic        high_rate,
  input  wire logic [2:0]  phy_mode,
  // receiver measurements
  input  wire logic        symbol_tick,
  input  wire logic [15:0] rx_power_cdbm,
  input  wire logic        carrier_detect,
  input  wire logic        sync_detect,
  // events and controls
  output logic             measure_done_irq,
  output logic             preamble_detect_disable
);

  typedef enum logic [1:0] {ST_IDLE, ST_LISTEN, ST_PROC, ST_WAIT_AUTO} state_e;

  state_e             state_q, state_d;     // manual assessment sequencer
  logic [1:0]         mode_q;               // assess_mode
  logic [4:0]         channel_q;            // channel field, stored only
  logic [3:0]         thr_q;                // energy_threshold
  logic [3:0]         rsvd_q;               // reserved threshold bits
  logic               pdt_q;                // preamble_detect_disable
  logic               req_q;                // assess_request pulse
  logic               done_q;               // assess_done
  logic               idle_q;               // channel_idle_flag
  logic               irq_q;                // measure_done_irq
  logic [7:0]         rdata_q;              // read data
  logic [3:0]         sym_cnt_q;            // listen window symbols
  logic [10:0]        proc_cnt_q;           // processing delay count
  logic signed [18:0] acc_q;                // listen power sum
  logic               cs_seen_q;            // carrier seen in listen window
  logic               listen_ed_busy_q;     // listen energy decision
  logic               auto_run_q;           // automatic window running
  logic               auto_ran_q;           // window already used this frame
  logic               auto_done_q;          // automatic window finished
  logic               auto_busy_q;          // automatic energy decision
  logic [3:0]         auto_cnt_q;           // automatic window symbols
  logic signed [18:0] auto_acc_q;           // automatic power sum
  logic signed [17:0] floor_cdbm;           // power_floor_dbm
  logic signed [18:0] busy_power_level;     // threshold in centi-dBm
  logic signed [18:0] sample;               // sign-extended power sample
  logic signed [18:0] listen_sum;           // sum including this sample
  logic signed [18:0] auto_sum;             // auto sum including sample
  logic [3:0]         auto_len;             // automatic window length
  logic               req_take;             // request is taken now
  logic               finish;               // assessment completes now
  logic               finish_idle;          // idle result at completion
  logic               auto_start;           // automatic window starts
  logic               auto_last;            // last automatic symbol

  // busy decision from the selected mode
  function automatic logic busy_of(input logic [1:0] m, input logic cs,
                                   input logic ed);
    logic b;
    b = 1'b0;
    unique case (m)
      cca_pkg::MODE_OR:      b = cs | ed;
      cca_pkg::MODE_ENERGY:  b = ed;
      cca_pkg::MODE_CARRIER: b = cs;
      cca_pkg::MODE_AND:     b = cs & ed;
    endcase
    return b;
  endfunction

  // power floor by phy mode
  always_comb begin
    unique case (phy_mode)
      cca_pkg::PHY_BPSK_300, cca_pkg::PHY_BPSK_600: floor_cdbm = cca_pkg::FLOOR_BPSK_CDBM;
      cca_pkg::PHY_OQPSK_400, cca_pkg::PHY_OQPSK_SIN: floor_cdbm = cca_pkg::FLOOR_OQPSK_CDBM;
      cca_pkg::PHY_OQPSK_RC: floor_cdbm = cca_pkg::FLOOR_RC_CDBM;
      default: floor_cdbm = cca_pkg::FLOOR_RC_CDBM;  // unused codes
    endcase
  end

  // threshold and window sums
  always_comb begin
    busy_power_level = 19'(floor_cdbm)
                     + $signed({1'b0, 18'({14'h0, thr_q}) * cca_pkg::THR_STEP_CDBM});
    sample     = 19'($signed(rx_power_cdbm));
    listen_sum = acc_q + sample;
    auto_sum   = auto_acc_q + sample;
    auto_len   = high_rate ? cca_pkg::HIGH_RATE_SYMBOLS : cca_pkg::LISTEN_SYMBOLS;
    auto_start = sync_detect & rx_busy & ~auto_ran_q & ~pdt_q;
    auto_last  = auto_run_q & symbol_tick & (auto_cnt_q == auto_len - 4'h1);
    req_take   = req_q;
  end

  // sequencer next state and completion
  always_comb begin
    state_d     = state_q;
    finish      = 1'b0;
    finish_idle = 1'b0;
    if (req_take) begin
      if (!basic_mode || !(rx_listen || rx_busy)) begin
        finish  = 1'b1;
        state_d = ST_IDLE;
      end else if (rx_listen) begin
        state_d = ST_LISTEN;
      end else if (mode_q == cca_pkg::MODE_CARRIER) begin
        finish      = 1'b1;
        finish_idle = ~busy_of(mode_q, carrier_detect, 1'b0);
        state_d     = ST_IDLE;
      end else if (auto_done_q) begin
        finish      = 1'b1;
        finish_idle = ~busy_of(mode_q, carrier_detect, auto_busy_q);
        state_d     = ST_IDLE;
      end else begin
        state_d = ST_WAIT_AUTO;
      end
    end else begin
      unique case (state_q)
        ST_IDLE: state_d = ST_IDLE;
        // fixed 8-symbol window, also when preamble detect is off
        ST_LISTEN: begin
          if (symbol_tick && sym_cnt_q == cca_pkg::LISTEN_SYMBOLS - 4'h1) begin
            state_d = ST_PROC;
          end
        end
        // processing delay before the answer
        ST_PROC: begin
          if (proc_cnt_q == cca_pkg::PROC_CYCLES - 11'h1) begin
            finish      = 1'b1;
            finish_idle = ~busy_of(mode_q, cs_seen_q, listen_ed_busy_q);
            state_d     = ST_IDLE;
          end
        end
        // answer once the frame's energy window closes
        ST_WAIT_AUTO: begin
          if (auto_done_q) begin
            finish      = 1'b1;
            finish_idle = ~busy_of(mode_q, carrier_detect, auto_busy_q);
            state_d     = ST_IDLE;
          end else if (!rx_busy) begin
            finish  = 1'b1;  // frame lost: report busy
            state_d = ST_IDLE;
          end
        end
      endcase
    end
  end

  // sequencer state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // listen window counters and averaging
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sym_cnt_q        <= 4'h0;
      proc_cnt_q       <= 11'h000;
      acc_q            <= 19'h00000;
      cs_seen_q        <= 1'b0;
      listen_ed_busy_q <= 1'b0;
    end else if (req_take) begin
      sym_cnt_q  <= 4'h0;
      proc_cnt_q <= 11'h000;
      acc_q      <= 19'h00000;
      cs_seen_q  <= 1'b0;
    end else if (state_q == ST_LISTEN) begin
      cs_seen_q <= cs_seen_q | carrier_detect;
      if (symbol_tick) begin
        sym_cnt_q <= sym_cnt_q + 4'h1;
        acc_q     <= listen_sum;
        // mean over the whole window against the threshold
        listen_ed_busy_q <= (listen_sum >>> 3) > busy_power_level;
      end
    end else if (state_q == ST_PROC) begin
      proc_cnt_q <= proc_cnt_q + 11'h001;
    end
  end

  // automatic energy window, once per frame
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      auto_run_q  <= 1'b0;
      auto_ran_q  <= 1'b0;
      auto_done_q <= 1'b0;
      auto_busy_q <= 1'b0;
      auto_cnt_q  <= 4'h0;
      auto_acc_q  <= 19'h00000;
    end else if (!rx_busy) begin
      auto_run_q  <= 1'b0;  // frame over: rearm
      auto_ran_q  <= 1'b0;
      auto_done_q <= 1'b0;
    end else if (auto_start) begin
      auto_run_q <= 1'b1;
      auto_ran_q <= 1'b1;
      auto_cnt_q <= 4'h0;
      auto_acc_q <= 19'h00000;
    end else if (auto_run_q && symbol_tick) begin
      auto_cnt_q <= auto_cnt_q + 4'h1;
      auto_acc_q <= auto_sum;
      if (auto_last) begin
        auto_run_q  <= 1'b0;
        auto_done_q <= 1'b1;
        auto_busy_q <= (high_rate ? (auto_sum >>> 1) : (auto_sum >>> 3))
                       > busy_power_level;
      end
    end
  end

  // configuration registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_q    <= cca_pkg::MODE_RESET;
      channel_q <= cca_pkg::CHANNEL_RESET;
      thr_q     <= cca_pkg::THR_RESET;
      rsvd_q    <= cca_pkg::RSVD_RESET;
      pdt_q     <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == cca_pkg::CTRL_ADDR) begin
        mode_q    <= reg_wdata[cca_pkg::MODE_LO +: 2];
        channel_q <= reg_wdata[4:0];
      end
      if (reg_addr == cca_pkg::THRES_ADDR) begin
        thr_q  <= reg_wdata[cca_pkg::THR_LO +: 4];
        rsvd_q <= reg_wdata[7:4];
      end
      if (reg_addr == cca_pkg::SYNC_ADDR) begin
        pdt_q <= reg_wdata[cca_pkg::PDT_BIT];
      end
    end
  end

  // request bit: one cycle, cleared as the sequencer takes it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      req_q <= 1'b0;
    end else begin
      req_q <= reg_wr & (reg_addr == cca_pkg::CTRL_ADDR)
             & reg_wdata[cca_pkg::REQ_BIT];
    end
  end

  // status flags: completion set wins over request clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      done_q <= 1'b0;
      idle_q <= 1'b0;
    end else if (finish) begin
      done_q <= 1'b1;
      idle_q <= finish_idle;
    end else if (req_take) begin
      done_q <= 1'b0;
      idle_q <= 1'b0;
    end
  end

  // completion interrupt pulse
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= finish;
    end
  end

  // register read mux; request bit reads as zero once taken
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        cca_pkg::STATUS_ADDR: rdata_q <= {done_q, idle_q, 1'b0, trx_state_code};
        cca_pkg::CTRL_ADDR:   rdata_q <= {req_q, mode_q, channel_q};
        cca_pkg::THRES_ADDR:  rdata_q <= {rsvd_q, thr_q};
        cca_pkg::SYNC_ADDR:   rdata_q <= {pdt_q, 7'h00};
        default:              rdata_q <= 8'h00;  // unmapped
      endcase
    end
  end

  // outputs straight from flops
  assign reg_rdata               = rdata_q;
  assign measure_done_irq        = irq_q;
  assign preamble_detect_disable = pdt_q;

endmodule
`default_nettype wire

// ==== verif/cca_sva.sv ====
// checker for the clear channel assessment unit, watching its ports only
// assumes one clock, async active-low reset, bound from the bench top file
`default_nettype none
module cca_sva (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst_b,
  // register port
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // state and events
  input wire logic [4:0] trx_state_code,
  input wire logic       basic_mode,
  input wire logic       rx_listen,
  input wire logic       rx_busy,
  input wire logic       measure_done_irq,
  input wire logic       preamble_detect_disable
);
  logic [7:0]  thr_q;  // shadow of threshold register
  logic [11:0] cnt_q;  // cycles since last request
  logic        req_q;  // request seen last cycle
  logic        lis_q;  // last request taken in listen state
  logic        req;    // request write on the port
  assign req = reg_wr && reg_addr == cca_pkg::CTRL_ADDR && reg_wdata[7];
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // shadow threshold, count request age, note listen state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      thr_q <= 8'h77;
      cnt_q <= 12'h000;
      req_q <= 1'b0;
      lis_q <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == cca_pkg::THRES_ADDR) thr_q <= reg_wdata;
      cnt_q <= req ? 12'h000 : cnt_q + {11'h000, cnt_q != 12'hFFF};
      req_q <= req;
      if (req_q) lis_q <= basic_mode && rx_listen;
    end
  end
  sequence req_s;
    req;
  endsequence
  sequence norx_s;
    !basic_mode || !(rx_listen || rx_busy);
  endsequence
  sequence busy_s;
    basic_mode && rx_busy && !rx_listen;
  endsequence
  irq_one_pulse_a: assert property (measure_done_irq |=> !measure_done_irq)
    else $error("done event longer than one cycle");
  rdata_holds_a: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");
  pdt_write_a: assert property (reg_wr && reg_addr == cca_pkg::SYNC_ADDR
    |=> preamble_detect_disable == $past(reg_wdata[7])) else $error("detect disable not written");
  pdt_hold_a: assert property (!(reg_wr && reg_addr == cca_pkg::SYNC_ADDR)
    |=> $stable(preamble_detect_disable)) else $error("detect disable changed alone");
  thres_read_a: assert property (reg_rd && reg_addr == cca_pkg::THRES_ADDR
    |=> reg_rdata == thr_q) else $error("threshold readback wrong");
  unmapped_read_a: assert property (reg_rd && !(reg_addr inside {8'h01, 8'h08, 8'h09,
    8'h15}) |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  status_read_a: assert property (reg_rd && reg_addr == cca_pkg::STATUS_ADDR
    |=> reg_rdata[5:0] == {1'b0, $past(trx_state_code)}) else $error("status low bits wrong");
  req_self_clear_a: assert property (reg_rd && reg_addr == cca_pkg::CTRL_ADDR && !req
    && !$past(req) |=> !reg_rdata[7]) else $error("request bit reads set");
  no_rx_done_a: assert property (req_s ##1 norx_s |=> measure_done_irq)
    else $error("no done event outside receive");
  busy_carrier_a: assert property (req_s ##0 reg_wdata[6:5] == 2'h2 ##1 busy_s
    |=> measure_done_irq) else $error("carrier result not immediate");
  listen_time_a: assert property (measure_done_irq && lis_q |-> cnt_q > 12'd1200)
    else $error("listen assessment ended early");
endmodule
`default_nettype wire

// ==== verif/rx_front_model.sv ====
// receiver front end model: symbol ticks, power, carrier and sync events
// assumes the bench sets power and carrier levels; 16 cycles per symbol
`default_nettype none
module rx_front_model (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst_b,
  // bench controls
  input  wire logic signed [15:0] pwr,
  input  wire logic               car,
  input  wire logic               sync_go,
  // receiver outputs
  output logic                    symbol_tick,
  output logic             [15:0] rx_power_cdbm,
  output logic                    carrier_detect,
  output logic                    sync_detect
);
  logic [3:0] div_q;  // symbol divider
  // symbol ticks and registered measurements
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_q <= 4'h0;
      symbol_tick <= 1'b0;
      rx_power_cdbm <= 16'h8000;
      carrier_detect <= 1'b0;
      sync_detect <= 1'b0;
    end else begin
      div_q <= div_q + 4'h1;
      symbol_tick <= div_q == 4'hF;
      rx_power_cdbm <= pwr;
      carrier_detect <= car;
      sync_detect <= sync_go;
    end
  end
endmodule
`default_nettype wire

// ==== verif/test_clear_channel_assessment.sv ====
// bench for the clear channel assessment unit, register tasks and scenarios
// assumes a 100 MHz clock and the front end model for receiver inputs
`default_nettype none
module test_clear_channel_assessment;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;  // clock, reset, strobes
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;    // register port
  logic [4:0] trx_state_code = 5'h06;                            // shown state code
  logic basic_mode = 1'b1, rx_listen = 1'b0, rx_busy = 1'b0;     // receiver state
  logic high_rate = 1'b0, car = 1'b0, sync_go = 1'b0;            // phy and model controls
  logic [2:0] phy_mode = 3'h0;                                   // phy selection
  logic signed [15:0] pwr = -16'sd9500;                          // channel power level
  logic symbol_tick, carrier_detect, sync_detect;                // model outputs
  logic [15:0] rx_power_cdbm;                                    // model power
  logic measure_done_irq, preamble_detect_disable;               // design events
  int num_errors = 0, samples_checked = 0;                       // verdict counters
  always #5 clk = ~clk;
  rx_front_model model_u (.clk(clk), .rst_b(rst_b), .pwr(pwr), .car(car), .sync_go(sync_go),
    .symbol_tick(symbol_tick), .rx_power_cdbm(rx_power_cdbm),
    .carrier_detect(carrier_detect), .sync_detect(sync_detect));
  clear_channel_assessment dut_u (.clk(clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .trx_state_code(trx_state_code), .basic_mode(basic_mode), .rx_listen(rx_listen),
    .rx_busy(rx_busy), .high_rate(high_rate), .phy_mode(phy_mode),
    .symbol_tick(symbol_tick), .rx_power_cdbm(rx_power_cdbm),
    .carrier_detect(carrier_detect), .sync_detect(sync_detect),
    .measure_done_irq(measure_done_irq), .preamble_detect_disable(preamble_detect_disable));
  // verdict and end of run
  task automatic close_out();
    if (num_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // compare and count
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, got);
      num_errors++;
    end
  endtask
  // one register write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk);
    #1 reg_wr = 1'b0;
  endtask
  // one register read, data valid the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
    @(posedge clk);
    #1 reg_rd = 1'b1;
    reg_addr = a;
    @(posedge clk);
    #1 reg_rd = 1'b0;
    chk(nm, exp, reg_rdata);
  endtask
  // request, optional cleared check, bounded wait, latency and status check
  task automatic run(input logic [1:0] m, input logic idle, input int lo, input int hi,
                     input bit clr);
    int n;
    wr(cca_pkg::CTRL_ADDR, {1'b1, m, 5'h00});
    n = 1;
    if (clr) begin
      @(posedge clk);
      rd(cca_pkg::STATUS_ADDR, {3'h0, trx_state_code}, "status_cleared");
      n = 4;
    end
    while (measure_done_irq !== 1'b1 && n <= hi) begin
      @(posedge clk);
      #1 n++;
    end
    chk("latency_in_window", 8'h01, {7'h00, n >= lo && n <= hi});
    rd(cca_pkg::STATUS_ADDR, {1'b1, idle, 1'b0, trx_state_code}, "status_done");
  endtask
  // busy decision per mode from energy and carrier
  function automatic logic bsy(input logic [1:0] m, input logic e, input logic c);
    case (m)
      2'h0: bsy = e | c;
      2'h1: bsy = e;
      2'h2: bsy = c;
      default: bsy = e & c;
    endcase
  endfunction
  // watchdog
  initial begin
    repeat (30000) @(posedge clk);
    num_errors++;
    close_out();
  end
  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    #1 rst_b = 1'b1;
    rd(cca_pkg::STATUS_ADDR, {3'h0, trx_state_code}, "status_reset");
    rd(cca_pkg::CTRL_ADDR, 8'h20, "ctrl_reset");
    rd(cca_pkg::THRES_ADDR, 8'h77, "thres_reset");
    rd(8'h30, 8'h00, "unmapped");
    wr(cca_pkg::THRES_ADDR, 8'hA5);
    rd(cca_pkg::THRES_ADDR, 8'hA5, "thres_rw");
    wr(cca_pkg::THRES_ADDR, 8'h05);
    wr(cca_pkg::CTRL_ADDR, 8'h40);
    rd(cca_pkg::CTRL_ADDR, 8'h40, "ctrl_rw");
    wr(cca_pkg::SYNC_ADDR, 8'h80);
    chk("detect_disable", 8'h01, {7'h00, preamble_detect_disable});
    wr(cca_pkg::SYNC_ADDR, 8'h00);
    run(2'h1, 1'b0, 2, 2, 1'b0);
    rx_listen = 1'b1;
    for (int k = 0; k < 8; k++) begin
      pwr = (k < 4) ? -16'sd8000 : -16'sd9500;
      car = k >= 4;
      run(2'(k), !bsy(2'(k), k < 4, k >= 4), 1312, 1360, 1'b1);
    end
    pwr = -16'sd8800;
    car = 1'b0;
    phy_mode = cca_pkg::PHY_OQPSK_RC;
    run(2'h1, 1'b1, 1312, 1360, 1'b0);
    phy_mode = cca_pkg::PHY_BPSK_300;
    run(2'h1, 1'b0, 1312, 1360, 1'b0);
    rx_listen = 1'b0;
    rx_busy = 1'b1;
    pwr = -16'sd9500;
    car = 1'b1;
    run(2'h2, 1'b0, 2, 2, 1'b0);
    pwr = -16'sd8000;
    car = 1'b0;
    sync_go = 1'b1;
    @(posedge clk);
    #1 sync_go = 1'b0;
    run(2'h1, 1'b0, 3, 150, 1'b0);
    run(2'h1, 1'b0, 2, 2, 1'b0);
    // new frame at high rate: two-symbol automatic window
    rx_busy = 1'b0;
    @(posedge clk);
    #1 rx_busy = 1'b1;
    high_rate = 1'b1;
    sync_go = 1'b1;
    @(posedge clk);
    #1 sync_go = 1'b0;
    run(2'h1, 1'b0, 3, 40, 1'b0);
    high_rate = 1'b0;
    rx_busy = 1'b0;
    close_out();
  end
endmodule
bind clear_channel_assessment cca_sva sva_u (.clk(clk), .rst_b(rst_b), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .trx_state_code(trx_state_code), .basic_mode(basic_mode), .rx_listen(rx_listen),
  .rx_busy(rx_busy), .measure_done_irq(measure_done_irq),
  .preamble_detect_disable(preamble_detect_disable));
`default_nettype wire
